/* core/tacc_map.vh */
// Constants for the tag authentication companion core.
// Assumes inclusion by bare name from the core module.
`ifndef TACC_MAP_VH
`define TACC_MAP_VH
`define TACC_CLK_MHZ        250
`define TACC_READY_MS       60
`define TACC_WAKE_MS        50
`define TACC_READY_CYC      (`TACC_READY_MS * 1000 * `TACC_CLK_MHZ)
`define TACC_WAKE_CYC       (`TACC_WAKE_MS * 1000 * `TACC_CLK_MHZ)
`define TACC_BLOCK_BYTES    64
`define TACC_KEY_SETS       16
`define TACC_KEY_BITS       64
`define TACC_PW_SETS        8
`define TACC_PW_BITS        24
`define TACC_CNT_NUM        4
`define TACC_CNT_MAX        6400000
`define TACC_LEN_POS        0
`define TACC_PAD_BYTE       8'h80
`define TACC_ADDR_RST       7'h5_0
`define TACC_LFSR_RST       32'hACE1_0001
`endif

/* core/tacc_core.v */
// Tag authentication companion core: power-up readiness, reset, sleep,
// two-wire slave address phase, secret storage and single-block hash input.
// Assumes clk_in at 250 MHz; bus lines and strap pins arrive asynchronously.
//
// Operation
// (R01) Hash input joins operands in order, padded to one 64-byte block.
// (R02) Only one compression round per digest; never more than one block.
// (R03) Tag secret input is common secret, tag identifier, host diversifier.
// (R04) Host supplies the diversifier, by any method it chooses.
// (R05) Random source output seeds the mutual authentication challenge.
// (R06) Host continues tag work only after both sides confirm.
// (R07) Ready for commands 60 ms after reset release; host waits.
// (R08) Low reset pin returns every state to initial, even while sleeping. Key and password storage keeps its contents.
// (R09) Sleep pin high: device sleeps and ignores both bus lines.
// (R10) Bus ignored for 50 ms after sleep falls; host waits.
// (R11) Sixteen diversified host key sets of 64 bits each.
// (R12) Eight password sets, each two 24-bit passwords.
// (R13) Four up-only counters, each limited to about 6.4 million.
// (R14) Slave only; clock line never held low.
// (R15) Address not acknowledged during readiness or wake intervals.
// (R16) Reset or sleep abandons a command without response or update.
`timescale 1ns/1ps
`include "tacc_map.vh"
module tacc_core #(
	parameter integer READY_CYC = `TACC_READY_CYC,
	parameter integer WAKE_CYC  = `TACC_WAKE_CYC,
	parameter integer KEY_SETS  = `TACC_KEY_SETS,
	parameter integer PW_SETS   = `TACC_PW_SETS,
	parameter integer CNT_NUM   = `TACC_CNT_NUM
) (
	input  wire         clk_in,
	input  wire         srst_in,
	input  wire         reset_n_in,
	input  wire         sleep_request_input_in,
	input  wire         scl_in,
	input  wire         sda_in,
	input  wire [6:0]   slave_addr_in,
	input  wire [159:0] common_secret_in,
	input  wire [63:0]  tag_id_in,
	input  wire [63:0]  host_diversifier_in,
	input  wire         derive_req_in,
	input  wire         key_we_in,
	input  wire [3:0]   key_idx_in,
	input  wire [63:0]  key_data_in,
	input  wire         pw_we_in,
	input  wire [2:0]   pw_idx_in,
	input  wire [47:0]  pw_data_in,
	input  wire         cnt_inc_in,
	input  wire [1:0]   cnt_idx_in,
	output reg          sda_out,
	output reg          sda_oe_out,
	output reg          scl_out,
	output reg          scl_oe_out,
	output reg          ready_out,
	output reg          sleep_state_out,
	output reg  [511:0] hash_block_out,
	output reg          hash_start_out,
	output reg  [63:0]  challenge_seed_out,
	output reg  [63:0]  key_rd_out,
	output reg  [47:0]  pw_rd_out,
	output reg  [22:0]  cnt_rd_out
);
	localparam ST_RESET = 4'b0001;
	localparam ST_BOOT  = 4'b0010;
	localparam ST_RUN   = 4'b0100;
	localparam ST_SLEEP = 4'b1000;
	localparam [22:0] CNT_MAX = `TACC_CNT_MAX;
	localparam [63:0] MSG_BITS = 64'h0000_0000_0000_0160;

	////////////////////////////////////////////////////////////////////
	// Input synchronisers
	wire rst_n_s;
	wire asleep;
	wire scl_s;
	wire sda_s;
	tacc_sync2 #(
		.WIDTH(1)
	) rst_sync_inst (
		.clk_in(clk_in),
		.d_in  (reset_n_in),
		.q_out (rst_n_s)
	);
	tacc_sync2 #(
		.WIDTH(1)
	) slp_sync_inst (
		.clk_in(clk_in),
		.d_in  (sleep_request_input_in),
		.q_out (asleep)
	);
	tacc_sync2 #(
		.WIDTH(1)
	) scl_sync_inst (
		.clk_in(clk_in),
		.d_in  (scl_in),
		.q_out (scl_s)
	);
	tacc_sync2 #(
		.WIDTH(1)
	) sda_sync_inst (
		.clk_in(clk_in),
		.d_in  (sda_in),
		.q_out (sda_s)
	);
	wire pin_rst = srst_in | ~rst_n_s; // [R08]

	////////////////////////////////////////////////////////////////////
	// Readiness and wake sequencing
	reg [3:0]  state_ff;
	reg [31:0] wait_ff;
	always @(posedge clk_in) begin
		if (pin_rst) begin // [R08]
			state_ff <= ST_RESET;
			wait_ff  <= 32'h0000_0000;
		end else begin
			case (state_ff)
			ST_RESET: begin
				state_ff <= ST_BOOT;
				wait_ff  <= READY_CYC[31:0]; // [R07]
			end
			ST_BOOT: begin
				if (wait_ff <= 32'h0000_0001)
					state_ff <= ST_RUN;
				wait_ff <= wait_ff - 32'h0000_0001;
				if (asleep)
					state_ff <= ST_SLEEP;
			end
			ST_RUN: begin
				if (asleep)
					state_ff <= ST_SLEEP; // [R09]
			end
			ST_SLEEP: begin
				if (!asleep) begin
					state_ff <= ST_BOOT;
					wait_ff  <= WAKE_CYC[31:0]; // [R10]
				end
			end
			default: state_ff <= ST_RESET;
			endcase
		end
	end
	wire bus_live = (state_ff == ST_RUN);

	////////////////////////////////////////////////////////////////////
	// Two-wire slave address phase; SCL is never driven
	reg       scl_d_ff;
	reg       sda_d_ff;
	reg       act_ff;
	reg [3:0] bit_ff;
	reg [7:0] sh_ff;
	reg       ack_ff;
	reg [6:0] addr_ff;
	wire start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire rise  = scl_s & ~scl_d_ff;
	wire fall  = ~scl_s & scl_d_ff;
	always @(posedge clk_in) begin
		if (pin_rst || !bus_live) begin // [R15] [R16]
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			act_ff   <= 1'b0;
			bit_ff   <= 4'h0;
			sh_ff    <= 8'h00;
			ack_ff   <= 1'b0;
			addr_ff  <= pin_rst ? `TACC_ADDR_RST : slave_addr_in;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
			if (start) begin
				act_ff <= 1'b1;
				bit_ff <= 4'h0;
			end else if (stop) begin
				act_ff <= 1'b0;
				ack_ff <= 1'b0;
			end else if (act_ff && rise && bit_ff < 4'h8) begin
				sh_ff  <= {sh_ff[6:0], sda_s};
				bit_ff <= bit_ff + 4'h1;
			end else if (act_ff && fall && bit_ff == 4'h8 && !ack_ff) begin
				ack_ff <= (sh_ff[7:1] == addr_ff);
				if (sh_ff[7:1] != addr_ff)
					act_ff <= 1'b0;
			end else if (act_ff && fall && ack_ff) begin
				ack_ff <= 1'b0;
				act_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Random source: two free-running LFSRs, one per seed half
	reg [31:0] lfsr_ff;
	reg [31:0] lfsr_b_ff;
	wire       lfsr_fb   = lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0];
	wire       lfsr_b_fb = lfsr_b_ff[31] ^ lfsr_b_ff[21] ^ lfsr_b_ff[1] ^ lfsr_b_ff[0];
	always @(posedge clk_in) begin
		if (pin_rst) begin
			lfsr_ff   <= `TACC_LFSR_RST;
			lfsr_b_ff <= ~`TACC_LFSR_RST;
		end else begin
			lfsr_ff   <= {lfsr_ff[30:0], lfsr_fb};
			lfsr_b_ff <= {lfsr_b_ff[30:0], lfsr_b_fb};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Key, password and counter storage
	reg [63:0] key_mem [0:KEY_SETS-1]; // [R11]
	reg [47:0] pw_mem  [0:PW_SETS-1];  // [R12]
	reg [22:0] cnt_mem [0:CNT_NUM-1];
	wire       cnt_room = (cnt_mem[cnt_idx_in] < CNT_MAX);
	integer i;
	// Keys and passwords persist through reset
	always @(posedge clk_in) begin
		if (!pin_rst && bus_live) begin // [R16]
			if (key_we_in)
				key_mem[key_idx_in] <= key_data_in;
			if (pw_we_in)
				pw_mem[pw_idx_in] <= pw_data_in;
		end
	end
	// Up-only counters, saturating at the limit
	always @(posedge clk_in) begin
		if (pin_rst) begin
			for (i = 0; i < CNT_NUM; i = i + 1)
				cnt_mem[i] <= 23'h00_0000;
		end else if (bus_live && cnt_inc_in && cnt_room) begin // [R16]
			cnt_mem[cnt_idx_in] <= cnt_mem[cnt_idx_in] + 23'h00_0001; // [R13]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Hash block assembly
	wire [7:0]   pad_lead   = `TACC_PAD_BYTE;
	wire [151:0] pad_zero   = 152'h0;
	wire [287:0] msg_body   = {common_secret_in, tag_id_in, host_diversifier_in}; // [R03]
	wire [511:0] padded_blk = {msg_body, pad_lead, pad_zero, MSG_BITS}; // [R01]
	wire         take_req   = derive_req_in & bus_live; // [R16]

	////////////////////////////////////////////////////////////////////
	// Bus pin outputs; acknowledge held until the next clock fall
	always @(posedge clk_in) begin
		if (pin_rst) begin
			sda_out    <= 1'b0;
			sda_oe_out <= 1'b0;
			scl_out    <= 1'b0;
			scl_oe_out <= 1'b0;
		end else begin
			sda_out    <= 1'b0;
			sda_oe_out <= ack_ff & bus_live; // [R15]
			scl_out    <= 1'b0;
			scl_oe_out <= 1'b0; // [R14]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status outputs
	always @(posedge clk_in) begin
		if (pin_rst) begin
			ready_out       <= 1'b0;
			sleep_state_out <= 1'b0;
		end else begin
			ready_out       <= bus_live; // [R07]
			sleep_state_out <= (state_ff == ST_SLEEP); // [R09]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Hash block and challenge seed outputs
	always @(posedge clk_in) begin
		if (pin_rst) begin
			hash_block_out     <= 512'h0;
			hash_start_out     <= 1'b0;
			challenge_seed_out <= 64'h0000_0000_0000_0000;
		end else begin
			hash_start_out <= take_req; // [R02]
			if (take_req) begin
				hash_block_out     <= padded_blk; // [R01]
				challenge_seed_out <= {lfsr_ff, lfsr_b_ff}; // [R05]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Storage read-back, one cycle behind the index
	always @(posedge clk_in) begin
		if (pin_rst) begin
			key_rd_out <= 64'h0000_0000_0000_0000;
			pw_rd_out  <= 48'h0000_0000_0000;
			cnt_rd_out <= 23'h00_0000;
		end else begin
			key_rd_out <= key_mem[key_idx_in];
			pw_rd_out  <= pw_mem[pw_idx_in];
			cnt_rd_out <= cnt_mem[cnt_idx_in];
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for asynchronous pins
module tacc_sync2 #(
	parameter integer WIDTH = 1
) (
	input  wire             clk_in,
	input  wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] q_out
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] hold_ff;
	always @(posedge clk_in) begin
		meta_ff <= d_in;
		hold_ff <= meta_ff;
	end
	assign q_out = hold_ff;
endmodule

/* tb/tacc_props.sv */
// Checker for bus drive, readiness, sleep and hash block of the core.
// Assumes binding to tacc_core; sees its ports only.
`timescale 1ns/1ps
module tacc_props #(
	parameter integer READY_CYC = 400,
	parameter integer WAKE_CYC  = 200
) (
	input wire         clk_in,
	input wire         srst_in,
	input wire         reset_n_in,
	input wire         sleep_request_input_in,
	input wire         derive_req_in,
	input wire [159:0] common_secret_in,
	input wire [63:0]  tag_id_in,
	input wire [63:0]  host_diversifier_in,
	input wire         sda_out,
	input wire         sda_oe_out,
	input wire         scl_oe_out,
	input wire         ready_out,
	input wire         sleep_state_out,
	input wire [511:0] hash_block_out,
	input wire         hash_start_out,
	input wire [22:0]  cnt_rd_out
);
	reg [31:0] quiet_ff;
	reg        boot_ff;
	// Cycles since reset or sleep release, until ready
	always @(posedge clk_in) begin
		if (srst_in || !reset_n_in || sleep_request_input_in || ready_out) begin
			quiet_ff <= 32'h0000_0000;
		end else begin
			quiet_ff <= quiet_ff + 32'h0000_0001;
		end
		boot_ff <= (srst_in || !reset_n_in) | (boot_ff & !sleep_request_input_in);
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	property p_slave;
		!scl_oe_out && !(sda_oe_out && sda_out);
	endproperty
	a_slave: assert property (p_slave) else $error("bad drive");
	property p_take;
		derive_req_in && ready_out |=> hash_start_out;
	endproperty
	a_take: assert property (p_take) else $error("no start");
	property p_lone;
		hash_start_out |-> $past(derive_req_in);
	endproperty
	a_lone: assert property (p_lone) else $error("extra start");
	property p_pad;
		hash_start_out |-> hash_block_out[223:0] == {8'h80, 152'h0, 64'h0000_0000_0000_0160};
	endproperty
	a_pad: assert property (p_pad) else $error("bad pad");
	property p_order;
		hash_start_out |-> hash_block_out[511:352] == $past(common_secret_in)
			&& hash_block_out[351:288] == $past(tag_id_in)
			&& hash_block_out[287:224] == $past(host_diversifier_in);
	endproperty
	a_order: assert property (p_order) else $error("bad order");
	property p_quiet;
		!ready_out && !$past(ready_out) |-> !sda_oe_out;
	endproperty
	a_quiet: assert property (p_quiet) else $error("ack");
	property p_rst;
		$fell(reset_n_in) |-> ##[1:6] !ready_out && !sleep_state_out;
	endproperty
	a_rst: assert property (p_rst) else $error("pin reset ignored");
	property p_sleep;
		(sleep_request_input_in && reset_n_in)[*6] |-> sleep_state_out && !ready_out;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep");
	property p_rdy_min;
		$rose(ready_out) |-> quiet_ff >= (boot_ff ? READY_CYC : WAKE_CYC);
	endproperty
	a_rdy_min: assert property (p_rdy_min) else $error("ready early");
	property p_rdy_max;
		quiet_ff < READY_CYC + 8;
	endproperty
	a_rdy_max: assert property (p_rdy_max) else $error("ready late");
	property p_cnt;
		cnt_rd_out <= 23'h61_A800;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count over");
endmodule
bind tacc_core tacc_props #(.READY_CYC(READY_CYC), .WAKE_CYC(WAKE_CYC)) tacc_props_inst (
	.clk_in, .srst_in, .reset_n_in, .sleep_request_input_in, .derive_req_in, .common_secret_in,
	.tag_id_in, .host_diversifier_in, .sda_out, .sda_oe_out, .scl_oe_out, .ready_out,
	.sleep_state_out, .hash_block_out, .hash_start_out, .cnt_rd_out);

/* tb/tacc_host.sv */
// Bus master model: address-only frames, lines released high when idle.
// Assumes pull-ups; the bench resolves the data line level.
`timescale 1ns/1ps
module tacc_host (
	input  wire clk_in,
	input  wire sda_in,
	output reg  scl_out,
	output reg  sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic hold;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic send_addr(input [7:0] b, output ack);
		integer i;
		sda_out = 1'b0;
		hold;
		for (i = 0; i < 9; i++) begin
			scl_out = 1'b0;
			sda_out = (i == 8) ? 1'b1 : b[7-i];
			hold;
			scl_out = 1'b1;
			hold;
		end
		ack = !sda_in;
		scl_out = 1'b0;
		sda_out = 1'b0;
		hold;
		scl_out = 1'b1;
		hold;
		sda_out = 1'b1;
		hold;
	endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench: boot, hash block, storage, sleep and pin reset.
// Assumes shortened readiness and wake counts.
`timescale 1ns/1ps
module testbench;
	localparam integer RDY = 400;
	reg clk_in = 1'b0, srst = 1'b1, rst_n = 1'b1, slp = 1'b0, drv = 1'b0;
	reg kwe = 1'b0, pwe = 1'b0, inc = 1'b0;
	reg [159:0] sec = {5{32'h1357_9BDF}};
	reg [63:0] id = 64'hA5A5_0F0F_1234_5678, dv = 64'hC3C3_8899_AABB_CCDD;
	reg [63:0] kd = 64'hFEED_0000_BEEF_0001;
	reg [47:0] pd = 48'h1234_5678_9ABC;
	wire sda_oe, rdy, ss, hs, hscl, hsda;
	wire [511:0] blk;
	wire [63:0] krd;
	wire [47:0] prd;
	wire [22:0] crd;
	wire [63:0] cs;
	reg [63:0] cs0;
	wire sda = hsda & ~sda_oe;
	integer fail_count = 0, samples_checked = 0;
	time t0;
	always #2 clk_in = ~clk_in;
	tacc_host tacc_host_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(hscl), .sda_out(hsda));
	tacc_core #(.READY_CYC(RDY), .WAKE_CYC(200)) tacc_core_inst (.clk_in(clk_in), .srst_in(srst),
		.reset_n_in(rst_n), .sleep_request_input_in(slp), .scl_in(hscl), .sda_in(sda),
		.slave_addr_in(7'h50), .common_secret_in(sec), .tag_id_in(id), .host_diversifier_in(dv),
		.derive_req_in(drv), .key_we_in(kwe), .key_idx_in(4'hF), .key_data_in(kd), .pw_we_in(pwe),
		.pw_idx_in(3'h7), .pw_data_in(pd), .cnt_inc_in(inc), .cnt_idx_in(2'h3), .sda_out(),
		.sda_oe_out(sda_oe), .scl_out(), .scl_oe_out(), .ready_out(rdy), .sleep_state_out(ss),
		.hash_block_out(blk), .hash_start_out(hs), .challenge_seed_out(cs), .key_rd_out(krd),
		.pw_rd_out(prd), .cnt_rd_out(crd));
	task chk(input [511:0] got, input [511:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge clk_in);
		#1;
	endtask
	task addr(input [7:0] b, input exp);
		reg a;
		tacc_host_inst.send_addr(b, a);
		chk(a, exp);
	endtask
	task wait_rdy;
		integer n;
		n = 0;
		while (rdy !== 1'b1 && n < 1000) begin
			step;
			n++;
		end
	endtask
	task test_done;
		if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_boot;
		addr(8'hA0, 1'b0);
		wait_rdy;
		chk(($time - t0) / 4 >= RDY && ($time - t0) / 4 <= RDY + 10, 1'b1);
		addr(8'hA0, 1'b1);
		addr(8'hA2, 1'b0);
	endtask
	task t_hash;
		drv = 1'b1;
		step;
		drv = 1'b0;
		chk(hs, 1'b1);
		chk(blk, {sec, id, dv, 8'h80, 152'h0, 64'h0000_0000_0000_0160});
		cs0 = cs;
		step;
		chk(hs, 1'b0);
		drv = 1'b1;
		step;
		drv = 1'b0;
		chk(hs, 1'b1);
		chk(cs != cs0, 1'b1);
	endtask
	task t_store;
		{kwe, pwe, inc} = 3'h7;
		step;
		{kwe, pwe} = 2'h0;
		step;
		inc = 1'b0;
		repeat (2) step;
		chk(krd, kd);
		chk(prd, pd);
		chk(crd, 23'h00_0002);
	endtask
	task t_sleep;
		slp = 1'b1;
		repeat (6) step;
		chk({ss, rdy}, 2'h2);
		addr(8'hA0, 1'b0);
		rst_n = 1'b0;
		repeat (6) step;
		chk(ss, 1'b0);
		rst_n = 1'b1;
		repeat (8) step;
		chk(ss, 1'b1);
		slp = 1'b0;
		addr(8'hA0, 1'b0);
		wait_rdy;
		addr(8'hA0, 1'b1);
	endtask
	initial begin
		repeat (6) step;
		srst = 1'b0;
		t0 = $time;
		t_boot;
		t_hash;
		t_store;
		t_sleep;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		test_done;
	end
endmodule
